// *** gip_global_irq.sv ***
// Local design decision: the AXI4-Lite register port.
module gip_global_irq
  import gip_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [NUM_BYTES-1:0] s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire gip_mod_type         summary_in,
  output logic                     host_int_n,
  output logic                     evt_irq,
  input  wire logic [AV_W-1:0]     av_port_a_in,
  output gip_pin_out_type          av_port_a_out,
  input  wire logic [AV_W-1:0]     av_port_b_in,
  output gip_pin_out_type          av_port_b_out,
  input  wire logic [AV_W-1:0]     rx_data,
  output logic [AV_W-1:0]          tx_data,
  output logic                     port_a_direction
);

  // ******************************************************************
  // declarations
  // ******************************************************************
  gip_wr_state_type     wr_state_ff;
  gip_wr_state_type     nxt_wr_state;
  gip_rd_state_type     rd_state_ff;
  logic [ADDR_W-1:0]    awaddr_ff;
  logic [DATA_W-1:0]    wdata_ff;
  logic [NUM_BYTES-1:0] wstrb_ff;
  logic                 wr_go_ff;
  logic [1:0]           bresp_ff;
  logic [DATA_W-1:0]    rdata_ff;
  logic [1:0]           rresp_ff;
  gip_csr_type          csr_ff;
  gip_mod_type          summary_ff;
  logic [NUM_MOD-1:0]   evt_stat_ff;
  logic [NUM_MOD-1:0]   evt_mask_ff;
  logic                 host_int_n_ff;
  gip_pin_out_type      port_a_ff;
  gip_pin_out_type      port_b_ff;
  logic [AV_W-1:0]      tx_data_ff;
  logic                 aw_hs;
  logic                 w_hs;
  logic                 ar_hs;
  logic [ADDR_W-1:0]    wr_word;
  logic [ADDR_W-1:0]    rd_word;
  logic [ADDR_W-1:0]    nxt_awaddr;
  logic [DATA_W-1:0]    wr_merged;
  logic [NUM_MOD-1:0]   evt_set;
  logic [NUM_MOD-1:0]   evt_clr;
  // helper nets for the gates, the mask merge, the write accept and the pin drivers
  logic [DATA_W-1:0]    mask_merged;
  logic [NUM_MOD-1:0]   gated_req;
  logic                 wr_accept;
  logic                 port_a_drive;
  logic                 port_b_drive;

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0]    old_w,
                                              input logic [DATA_W-1:0]    new_w,
                                              input logic [NUM_BYTES-1:0] strb);
    logic [DATA_W-1:0] m;
    m = old_w;
    for (int i = 0; i < NUM_BYTES; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // ******************************************************************
  // write channel
  // ******************************************************************
  // address and data are taken in either order; the register update
  // happens one cycle after the second of them, at the edge that ends the first bvalid cycle
  // protection attributes are ignored: any master may reach every register
  assign s_axi_awready = (wr_state_ff == WR_IDLE) || (wr_state_ff == WR_DATA);
  assign s_axi_wready  = (wr_state_ff == WR_IDLE) || (wr_state_ff == WR_ADDR);
  assign s_axi_bvalid  = (wr_state_ff == WR_RESP);
  assign s_axi_bresp   = bresp_ff;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign nxt_awaddr    = aw_hs ? s_axi_awaddr : awaddr_ff;
  assign wr_word       = awaddr_ff & WORD_MASK;
  // the cycle in which the second half of a write is taken
  assign wr_accept     = (nxt_wr_state == WR_RESP) && (wr_state_ff != WR_RESP);

  always_comb begin
    nxt_wr_state = wr_state_ff;
    case (wr_state_ff)
      WR_IDLE: begin
        if (aw_hs && w_hs) begin
          nxt_wr_state = WR_RESP;
        end else if (aw_hs) begin
          nxt_wr_state = WR_ADDR;
        end else if (w_hs) begin
          nxt_wr_state = WR_DATA;
        end
      end
      WR_ADDR: begin
        if (w_hs) begin
          nxt_wr_state = WR_RESP;
        end
      end
      WR_DATA: begin
        if (aw_hs) begin
          nxt_wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wr_state = WR_IDLE;
        end
      end
      default: nxt_wr_state = WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= WR_IDLE;
      awaddr_ff   <= '0;
      wdata_ff    <= '0;
      wstrb_ff    <= '0;
      wr_go_ff    <= 1'h0;
      bresp_ff    <= RESP_OKAY;
    end else begin
      wr_state_ff <= nxt_wr_state;
      wr_go_ff    <= wr_accept;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      // decode the address being taken now: awaddr_ff may not hold it yet
      if (wr_accept) begin
        case (nxt_awaddr & WORD_MASK)
          OFF_GLOB_CSR, OFF_EVT_STATUS, OFF_EVT_MASK: bresp_ff <= RESP_OKAY;
          default:                                    bresp_ff <= RESP_SLVERR;
        endcase
      end
    end
  end

  // ******************************************************************
  // read channel
  // ******************************************************************
  assign s_axi_arready = (rd_state_ff == RD_IDLE);
  assign s_axi_rvalid  = (rd_state_ff == RD_RESP);
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign rd_word       = s_axi_araddr & WORD_MASK;

  // rdata is loaded at the address handshake and stands until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= RD_IDLE;
      rdata_ff    <= '0;
      rresp_ff    <= RESP_OKAY;
    end else begin
      case (rd_state_ff)
        RD_IDLE: begin
          if (ar_hs) begin
            rd_state_ff <= RD_RESP;
            rresp_ff    <= RESP_OKAY;
            case (rd_word)
              // summary bits read live, with no acknowledge needed
              OFF_GLOB_CSR:   rdata_ff <= csr_to_word(csr_ff, summary_ff);
              OFF_EVT_STATUS: rdata_ff <= DATA_W'(evt_stat_ff);
              OFF_EVT_MASK:   rdata_ff <= DATA_W'(evt_mask_ff);
              default: begin
                rdata_ff <= '0;
                rresp_ff <= RESP_SLVERR;
              end
            endcase
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_ff <= RD_IDLE;
          end
        end
        default: rd_state_ff <= RD_IDLE;
      endcase
    end
  end

  // ******************************************************************
  // control register
  // ******************************************************************
  // writes to the summary bits are dropped: they only mirror the modules
  // byte strobes act lane by lane on the word as it reads back
  assign wr_merged = merge(csr_to_word(csr_ff, summary_ff), wdata_ff, wstrb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_ff <= CSR_RESET;
    end else if (wr_go_ff && (wr_word == OFF_GLOB_CSR)) begin
      csr_ff <= csr_from_word(wr_merged);
    end
  end

  // ******************************************************************
  // interrupt aggregation
  // ******************************************************************
  // gate bits 11..8 pair with summaries 3..0; a clear gate blocks its
  // module whatever that module's own enables hold
  for (genvar g = 0; g < NUM_MOD; g++) begin : g_gate
    assign gated_req[g] = summary_in[g] & csr_ff.gate[g];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      summary_ff    <= '0;
      host_int_n_ff <= 1'h1;
    end else begin
      summary_ff    <= summary_in;
      host_int_n_ff <= ~|gated_req;
    end
  end

  assign host_int_n = host_int_n_ff;

  // ******************************************************************
  // sticky event flags
  // ******************************************************************
  // a rising summary sets its flag; set wins over a same-cycle clear
  // summary_ff resets to the idle level, so no false event follows reset
  assign evt_set = summary_in & ~summary_ff;
  assign evt_clr = (wr_go_ff && (wr_word == OFF_EVT_STATUS)) ?
                   (wr_merged[NUM_MOD-1:0] & {NUM_MOD{wstrb_ff[0]}}) : '0;
  assign mask_merged = merge(DATA_W'(evt_mask_ff), wdata_ff, wstrb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_ff <= EVT_STAT_RESET;
    end else begin
      evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask_ff <= EVT_MASK_RESET;
    end else if (wr_go_ff && (wr_word == OFF_EVT_MASK)) begin
      evt_mask_ff <= mask_merged[NUM_MOD-1:0];
    end
  end

  assign evt_irq = |(evt_stat_ff & evt_mask_ff);

  // ******************************************************************
  // av port direction
  // ******************************************************************
  // a port drives its pins only as receiver and with its enable set;
  // otherwise it floats and may be sampled as an input. the direction
  // bit is in both terms, so the two ports can never drive together
  assign port_a_drive = csr_ff.port_a_output_enable &
                        ~csr_ff.port_a_direction;
  assign port_b_drive = csr_ff.port_b_output_enable &
                        csr_ff.port_a_direction;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_ff  <= '{data: '0, oe_n: 1'h1};
      port_b_ff  <= '{data: '0, oe_n: 1'h1};
      tx_data_ff <= '0;
    end else begin
      port_a_ff.data <= rx_data;
      port_b_ff.data <= rx_data;
      port_a_ff.oe_n <= ~port_a_drive;
      port_b_ff.oe_n <= ~port_b_drive;
      // the transmitting port's pins feed the transmitter
      tx_data_ff     <= csr_ff.port_a_direction ? av_port_a_in : av_port_b_in;
    end
  end

  assign av_port_a_out    = port_a_ff;
  assign av_port_b_out    = port_b_ff;
  assign tx_data          = tx_data_ff;
  assign port_a_direction = csr_ff.port_a_direction;

endmodule : gip_global_irq

// *** gip_pkg.sv ***
// Behaviour
// - direction bit one: port A transmits, pins input
// - direction bit zero: port A receives, pins output
// - port B always takes the opposite role
// - gate bit 11 passes async summary to interrupt
// - gate bit 10 passes iso transmit summary
// - gate bit 9 passes iso receive summary
// - gate bit 8 passes link/phy summary
// - summary bits 3..0 are read-only pending flags
// - summary bits clear themselves, no acknowledge
// - low interrupt held while any gated summary active
// - bits 18/17 enable port outputs; reset 0x00010000
package gip_pkg;

  // ******************************************************************
  // bus and pin widths
  // ******************************************************************
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int NUM_BYTES = DATA_W / 8;
  localparam int AV_W      = 8;
  localparam int NUM_MOD   = 4;

  // ******************************************************************
  // register map (byte addresses)
  // ******************************************************************
  localparam logic [ADDR_W-1:0] OFF_GLOB_CSR   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_TIMER      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK   = 8'h44;
  localparam logic [ADDR_W-1:0] WORD_MASK      = 8'hFC;

  // ******************************************************************
  // field layout and reset values
  // ******************************************************************
  localparam int BIT_OE_B    = 18;
  localparam int BIT_OE_A    = 17;
  localparam int BIT_DIR_A   = 16;
  localparam int BIT_GATE_LO = 8;
  localparam int BIT_SUM_LO  = 0;

  localparam logic [DATA_W-1:0]  GLOB_CSR_RESET  = 32'h0001_0000;
  localparam logic [NUM_MOD-1:0] EVT_MASK_RESET  = 4'h0;
  localparam logic [NUM_MOD-1:0] EVT_STAT_RESET  = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ******************************************************************
  // types
  // ******************************************************************
  // bit order matches status bits 3..0 and gate bits 11..8
  typedef struct packed {
    logic async_module_summary;
    logic iso_tx_summary;
    logic iso_rx_summary;
    logic link_phy_summary;
  } gip_mod_type;

  typedef struct packed {
    logic                port_b_output_enable;
    logic                port_a_output_enable;
    logic                port_a_direction;
    logic [NUM_MOD-1:0]  gate;
  } gip_csr_type;

  typedef struct packed {
    logic [AV_W-1:0] data;
    logic            oe_n;
  } gip_pin_out_type;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_DATA = 2'h2
  } gip_wr_state_type;

  typedef enum logic {
    RD_IDLE = 1'h0,
    RD_RESP = 1'h1
  } gip_rd_state_type;

  function automatic gip_csr_type csr_from_word(input logic [DATA_W-1:0] w);
    gip_csr_type c;
    c.port_b_output_enable = w[BIT_OE_B];
    c.port_a_output_enable = w[BIT_OE_A];
    c.port_a_direction     = w[BIT_DIR_A];
    c.gate                 = w[BIT_GATE_LO +: NUM_MOD];
    return c;
  endfunction : csr_from_word

  function automatic logic [DATA_W-1:0] csr_to_word(input gip_csr_type c,
                                                    input gip_mod_type s);
    logic [DATA_W-1:0] w;
    w                          = '0;
    w[BIT_OE_B]                = c.port_b_output_enable;
    w[BIT_OE_A]                = c.port_a_output_enable;
    w[BIT_DIR_A]               = c.port_a_direction;
    w[BIT_GATE_LO +: NUM_MOD]  = c.gate;
    w[BIT_SUM_LO +: NUM_MOD]   = s;
    return w;
  endfunction : csr_to_word

  localparam gip_csr_type CSR_RESET = csr_from_word(GLOB_CSR_RESET);

endpackage : gip_pkg

// *** gip_global_irq_sva.sv ***
module gip_global_irq_sva
  import gip_pkg::*;
(
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire gip_mod_type     summary_in,
  input wire logic            host_int_n,
  input wire logic [AV_W-1:0] av_port_a_in,
  input wire gip_pin_out_type av_port_a_out,
  input wire logic [AV_W-1:0] av_port_b_in,
  input wire gip_pin_out_type av_port_b_out,
  input wire logic [AV_W-1:0] rx_data,
  input wire logic [AV_W-1:0] tx_data,
  input wire logic            port_a_direction
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************************************
  // interrupt pin
  // ****************************************************************
  property p_no_src; summary_in == '0 |=> host_int_n; endproperty
  a_no_src: assert property (p_no_src) else $error("interrupt without any summary");
  property p_int_cause; !host_int_n |-> $past(summary_in) != '0; endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt with no cause");

  // ****************************************************************
  // port roles and read response; oe lags the direction bit by one cycle
  // ****************************************************************
  property p_oe_a; !av_port_a_out.oe_n |-> !$past(port_a_direction); endproperty
  a_oe_a: assert property (p_oe_a) else $error("port a driven while transmitting");
  property p_oe_b; !av_port_b_out.oe_n |-> $past(port_a_direction); endproperty
  a_oe_b: assert property (p_oe_b) else $error("port b driven while transmitting");
  property p_opp; !av_port_a_out.oe_n |-> av_port_b_out.oe_n; endproperty
  a_opp: assert property (p_opp) else $error("both ports driven");
  property p_tx_a;
    $past(aresetn) && $past(port_a_direction) |-> tx_data == $past(av_port_a_in);
  endproperty
  a_tx_a: assert property (p_tx_a) else $error("tx data not from port a");
  property p_tx_b;
    $past(aresetn) && !$past(port_a_direction) |-> tx_data == $past(av_port_b_in);
  endproperty
  a_tx_b: assert property (p_tx_b) else $error("tx data not from port b");
  property p_rx_a; $past(aresetn) |-> av_port_a_out.data == $past(rx_data); endproperty
  a_rx_a: assert property (p_rx_a) else $error("port a data not rx data");
  property p_rst;
    $rose(aresetn) |-> port_a_direction && av_port_a_out.oe_n && av_port_b_out.oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("wrong port state after reset");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("status read not answered");

  c_int: cover property (!host_int_n);
  c_drv_a: cover property (!av_port_a_out.oe_n);
  c_drv_b: cover property (!av_port_b_out.oe_n);
endmodule : gip_global_irq_sva

bind gip_global_irq gip_global_irq_sva i_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .summary_in(summary_in),
  .host_int_n(host_int_n), .av_port_a_in(av_port_a_in), .av_port_a_out(av_port_a_out),
  .av_port_b_in(av_port_b_in), .av_port_b_out(av_port_b_out), .rx_data(rx_data),
  .tx_data(tx_data), .port_a_direction(port_a_direction)
);

// *** gip_av_peer.sv ***
module gip_av_peer
  import gip_pkg::*;
(
  input  wire gip_pin_out_type dut_pins,
  input  wire logic [AV_W-1:0] peer_data,
  output logic [AV_W-1:0]      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // the peer drives only while the block has released the pins
  assign pin_level = dut_pins.oe_n ? peer_data : dut_pins.data;
endmodule : gip_av_peer

// *** gip_global_irq_tb.sv ***
module gip_global_irq_tb
  import gip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, host_int_n, evt_irq, port_a_direction, m_dir, m_oea, m_oeb;
  logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]    s_axi_wdata, s_axi_rdata, rdat;
  logic [NUM_BYTES-1:0] s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]           m_gate, m_sum;
  logic [AV_W-1:0]      rx_data, tx_data, peer_a, peer_b;
  wire  [AV_W-1:0]      av_port_a_in, av_port_b_in;
  gip_mod_type          summary_in;
  gip_pin_out_type      av_port_a_out, av_port_b_out;
  int                   error_cnt, tests_run;

  gip_global_irq i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .summary_in(summary_in), .host_int_n(host_int_n), .evt_irq(evt_irq),
    .av_port_a_in(av_port_a_in), .av_port_a_out(av_port_a_out), .av_port_b_in(av_port_b_in),
    .av_port_b_out(av_port_b_out), .rx_data(rx_data), .tx_data(tx_data),
    .port_a_direction(port_a_direction));
  gip_av_peer i_peer_a (.dut_pins(av_port_a_out), .peer_data(peer_a), .pin_level(av_port_a_in));
  gip_av_peer i_peer_b (.dut_pins(av_port_b_out), .peer_data(peer_b), .pin_level(av_port_b_in));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic stop_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wait_neg(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : wait_neg

  // handshake state is sampled mid-cycle, so it equals what the edge sees
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit done;
    bit ax;
    bit w;
    done = 0;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ax = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      w = s_axi_wvalid && s_axi_wready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      rdat = s_axi_rdata;
      @(posedge aclk);
      if (ax) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (w) s_axi_wvalid <= 1'b0;
      if (done) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    if (!done) begin
      error_cnt++;
      stop_test();
    end
  endtask : xfer

  function automatic logic [31:0] csr_exp();
    return {13'h0, m_oeb, m_oea, m_dir, 4'h0, m_gate, 4'h0, m_sum};
  endfunction : csr_exp

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_data, peer_a, peer_b} = '0;
    s_axi_wstrb = 4'hF;
    summary_in = '0;
    {m_oeb, m_oea, m_dir, m_gate, m_sum} = {3'h1, 8'h00};
    void'($urandom(70));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(0, OFF_GLOB_CSR, 0);
    chk("csr_reset", rdat, 32'h0001_0000);
    xfer(1, OFF_TIMER, 32'hFFFF_FFFF);
    chk("timer_wr_resp", rsp, RESP_SLVERR);
    xfer(0, OFF_TIMER, 0);
    chk("timer_rd", {rsp, rdat[29:0]}, {RESP_SLVERR, 30'h0});
    for (int i = 0; i < 12; i++) begin
      m_gate = (i < 8) ? 4'h1 << i[2:1] : 4'($urandom);
      m_sum = (i < 8) ? (i[0] ? 4'hF : ~m_gate) : 4'($urandom);
      m_sum = (i == 11) ? 4'h0 : m_sum;
      xfer(1, OFF_GLOB_CSR, csr_exp() ^ 32'hF);
      chk("csr_wr_resp", rsp, RESP_OKAY);
      @(posedge aclk);
      summary_in <= gip_mod_type'(m_sum);
      wait_neg(3);
      chk("host_int_n", host_int_n, ~|(m_sum & m_gate));
      xfer(0, OFF_GLOB_CSR, 0);
      chk("csr_rd", rdat, csr_exp());
      chk("int_hold", host_int_n, ~|(m_sum & m_gate));
      @(posedge aclk);
      summary_in <= '0;
      wait_neg(1);
      chk("int_release", host_int_n, 1'h1);
    end
    for (int i = 0; i < 4; i++) begin
      {m_oeb, m_oea, m_dir} = {i[1], i[1], i[0]};
      xfer(1, OFF_GLOB_CSR, csr_exp());
      @(posedge aclk);
      rx_data <= 8'($urandom);
      peer_a <= 8'($urandom);
      peer_b <= 8'($urandom);
      wait_neg(3);
      chk("oe_a", av_port_a_out.oe_n, !(m_oea && !m_dir));
      chk("oe_b", av_port_b_out.oe_n, !(m_oeb && m_dir));
      chk("tx_data", tx_data, m_dir ? peer_a : peer_b);
      chk("data_a", av_port_a_out.data, rx_data);
      chk("data_b", av_port_b_out.data, rx_data);
      chk("dir", port_a_direction, m_dir);
    end
    xfer(1, OFF_EVT_STATUS, 32'hF);
    for (int i = 0; i < 2; i++) begin
      xfer(1, OFF_EVT_MASK, i ? 32'h0 : 32'hF);
      m_sum = 4'($urandom) | 4'h1;
      @(posedge aclk);
      summary_in <= gip_mod_type'(m_sum);
      wait_neg(3);
      chk("evt_irq", evt_irq, i == 0);
      xfer(0, OFF_EVT_STATUS, 0);
      chk("evt_status", rdat, m_sum);
      xfer(1, OFF_EVT_STATUS, m_sum);
      wait_neg(0);
      chk("evt_clear", evt_irq, 0);
      @(posedge aclk);
      summary_in <= '0;
    end
    stop_test();
  end
endmodule : gip_global_irq_tb
